/* File: rtl/trm_ring_maint.sv */
// Purpose: ring maintenance and token handoff sequencing with Avalon-MM registers
// Assumes: receive events are single-cycle pulses synchronous to sys_clk
// Notes:   the transmitter accepts a frame request when tx_ready is high
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module trm_ring_maint
(
   input  wire logic               sys_clk,
   input  wire logic               srst,
   // avalon-mm slave
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   output logic                    irq,
   // access control machine events
   input  wire logic               handoff_req,
   input  wire logic               data_pending,
   input  wire logic               contention_end,
   input  wire logic               contention_won,
   input  wire logic               pass_ok,
   input  wire logic               pass_fail,
   input  wire logic               resp_timeout,
   input  wire logic               window_done,
   input  wire logic               retry_load,
   input  wire trm_pkg::trm_rx_s   rx,
   // transmitter side
   input  wire logic               tx_ready,
   output trm_pkg::trm_tx_s        tx,
   output logic                    retransmit,
   output logic                    faulty_transmitter,
   output logic                    offline,
   output logic                    in_ring,
   output logic                    lone_station
);
   trm_pkg::trm_state_e state_q, state_d;
   trm_pkg::trm_phase_e phase_q, phase_d;
   trm_pkg::trm_tx_s    tx_q, tx_d;
   logic [31:0] ctrl_q;
   logic [2:0]  irq_q;
   logic [2:0]  mask_q;
   logic [3:0]  retry_q;
   logic        first_q;
   logic        lone_q;
   logic        offline_q;
   logic        ack_q;
   logic [31:0] rdata_q;

   wire         fault_pulse;
   wire [2:0]   tally;
   wire         solicit;
   wire [7:0]   gap_count;

   // register decode
   wire   acc       = (avs_read || avs_write) && !ack_q;
   wire   wr        = avs_write && ack_q;   // writes land on the edge that ends the wait
   wire   wr_ctrl   = wr && avs_address == trm_pkg::OFF_CTRL;
   wire   wr_irq    = wr && avs_address == trm_pkg::OFF_IRQ;
   wire   wr_mask   = wr && avs_address == trm_pkg::OFF_MASK;
   wire   init      = wr_ctrl && avs_byteenable[1] && avs_writedata[trm_pkg::CTRL_INIT];
   wire [7:0] gap_reload  = ctrl_q[trm_pkg::CTRL_GAP_LSB +: 8];
   wire [3:0] retry_ceil  = ctrl_q[trm_pkg::CTRL_RETRY_LSB +: 4];
   wire   omit_check_sequence_flag = ctrl_q[trm_pkg::CTRL_OMIT];
   wire   in_pass   = state_q == trm_pkg::ST_PASS;
   // a lone station stays silent unless it has data of its own to send
   wire   gap_check = state_q == trm_pkg::ST_IDLE && handoff_req && !offline_q &&
                      (!lone_q || data_pending);
   wire   heard_inv = state_q == trm_pkg::ST_CHK_RESP && rx.heard_any;
   wire   noise_aw  = state_q == trm_pkg::ST_AWAIT && rx.noise;
   wire   total_ev  = in_pass && phase_q == trm_pkg::PH_TOTAL;
   wire   retry_ev  = resp_timeout && retry_q != 4'h0;
   wire   pass_done = pass_ok || (state_q == trm_pkg::ST_AWAIT && rx.successor);

   // byte-lane merge for writes
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction : be_merge

   function automatic trm_pkg::trm_phase_e next_phase(input trm_pkg::trm_phase_e p);
      return (p == trm_pkg::PH_TOTAL) ? p : trm_pkg::trm_phase_e'(p + 3'h1);
   endfunction : next_phase

   trm_fault_tally u_tally
   (
      .sys_clk (sys_clk),
      .srst    (srst),
      .init    (init),
      .inc     (contention_end || (pass_fail && phase_q == trm_pkg::PH_REQUERY)),
      .clr     (contention_won || pass_done),
      .tally   (tally),
      .fault   (fault_pulse)
   );

   trm_gap_counter u_gap
   (
      .sys_clk (sys_clk),
      .srst    (srst),
      .init    (init),
      .check   (gap_check),
      .heard   (heard_inv),
      .reload  (gap_reload),
      .solicit (solicit),
      .count   (gap_count)
   );

   // handoff sequencing
   always_comb
   begin
      state_d = state_q;
      phase_d = phase_q;
      tx_d    = tx_q;
      if (tx_q.valid && tx_ready)
         tx_d.valid = 1'b0;
      unique case (state_q)
         trm_pkg::ST_IDLE:
         begin
            if (gap_check)
            begin
               phase_d = solicit ? trm_pkg::PH_INVITE : trm_pkg::PH_PASS;
               state_d = trm_pkg::ST_PASS;
            end
         end
         trm_pkg::ST_PASS:
         begin
            if (!tx_q.valid)
            begin
               tx_d.valid      = 1'b1;
               tx_d.to_self    = 1'b0;
               tx_d.omit_check = omit_check_sequence_flag;
               unique case (phase_q)
                  trm_pkg::PH_INVITE:
                  begin
                     tx_d.kind = trm_pkg::FR_INVITE1;
                     state_d   = trm_pkg::ST_CHK_RESP;
                  end
                  trm_pkg::PH_PASS, trm_pkg::PH_REPASS:
                  begin
                     tx_d.kind = trm_pkg::FR_TOKEN;
                     state_d   = trm_pkg::ST_CHK_PASS;
                  end
                  trm_pkg::PH_QUERY, trm_pkg::PH_REQUERY:
                  begin
                     tx_d.kind = trm_pkg::FR_QUERY;
                     state_d   = trm_pkg::ST_AWAIT;
                  end
                  trm_pkg::PH_ALL:
                  begin
                     tx_d.kind    = trm_pkg::FR_INVITE2;
                     tx_d.to_self = 1'b1;
                     state_d      = trm_pkg::ST_AWAIT;
                  end
                  default:
                  begin
                     // total failure: silent self-pass or idle
                     tx_d.valid = 1'b0;
                     state_d    = trm_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         trm_pkg::ST_CHK_RESP:
         begin
            if (window_done)
            begin
               phase_d = trm_pkg::PH_PASS;
               state_d = trm_pkg::ST_PASS;
            end
         end
         trm_pkg::ST_CHK_PASS, trm_pkg::ST_AWAIT:
         begin
            if (pass_done)
               state_d = trm_pkg::ST_IDLE;
            else if (noise_aw && !first_q)
               state_d = trm_pkg::ST_IDLE;
            else if (pass_fail)
            begin
               phase_d = next_phase(phase_q);
               state_d = trm_pkg::ST_PASS;
            end
         end
         default:
            state_d = trm_pkg::ST_OFFLINE;
      endcase
      if (fault_pulse)
         state_d = trm_pkg::ST_OFFLINE;
   end

   // sequencer registers
   always_ff @(posedge sys_clk)
   begin
      if (srst || init)
      begin
         state_q <= trm_pkg::ST_IDLE;
         phase_q <= trm_pkg::PH_INVITE;
         tx_q    <= '0;
      end
      else
      begin
         state_q <= state_d;
         phase_q <= phase_d;
         tx_q    <= tx_d;
      end
   end

   // first-noise-pending flag, set on each await entry
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         first_q <= 1'b1;
      else if (state_d == trm_pkg::ST_AWAIT && state_q != trm_pkg::ST_AWAIT)
         first_q <= 1'b1;
      else if (noise_aw)
         first_q <= 1'b0;
   end

   // lone-station flag; total failure set wins over a foreign frame clear
   always_ff @(posedge sys_clk)
   begin
      if (srst || init)
         lone_q <= 1'b0;
      else if (total_ev)
         lone_q <= 1'b1;
      else if (rx.valid_other)
         lone_q <= 1'b0;
   end

   // offline latch left only by protocol init
   always_ff @(posedge sys_clk)
   begin
      if (srst || init)
         offline_q <= 1'b0;
      else if (fault_pulse)
         offline_q <= 1'b1;
   end

   // retry-left counter
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         retry_q <= trm_pkg::RETRY_RESET;
      else if (retry_load)
         retry_q <= retry_ceil;
      else if (retry_ev)
         retry_q <= retry_q - 4'h1;
   end

   // control, mask, sticky events (set wins over write-one clear)
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ctrl_q <= {19'h0, 1'b0, trm_pkg::RETRY_RESET, 8'h00};
         mask_q <= 3'h0;
         irq_q  <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable) & 32'h0000_1fff;
         if (wr_mask && avs_byteenable[0])
            mask_q <= avs_writedata[2:0];
         irq_q <= (irq_q & ~((wr_irq && avs_byteenable[0]) ? avs_writedata[2:0] : 3'h0))
                  | {retry_ev, total_ev, fault_pulse};
      end
   end

   // read data and one-wait-state handshake
   wire [31:0] status_w = {16'h0, gap_count, 1'b0, tally, lone_q, offline_q,
                           retry_q == 4'h0, in_ring};
   wire [31:0] rsel = (avs_address == trm_pkg::OFF_CTRL)   ? ctrl_q :
                      (avs_address == trm_pkg::OFF_STATUS) ? status_w :
                      (avs_address == trm_pkg::OFF_IRQ)    ? {29'h0, irq_q} :
                      (avs_address == trm_pkg::OFF_MASK)   ? {29'h0, mask_q} : 32'h0;
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end
      else
      begin
         ack_q   <= acc;
         rdata_q <= avs_read ? rsel : rdata_q;
      end
   end

   assign avs_waitrequest    = (avs_read || avs_write) && !ack_q;
   assign avs_readdata       = rdata_q;
   assign irq                = |(irq_q & mask_q);
   assign tx                 = tx_q;
   assign retransmit         = retry_ev;
   assign faulty_transmitter = fault_pulse;
   assign offline            = offline_q;
   assign in_ring            = !offline_q;
   assign lone_station       = lone_q;

   chk_await_first: assert property (@(posedge sys_clk) disable iff (srst)
      state_q != trm_pkg::ST_AWAIT ##1 state_q == trm_pkg::ST_AWAIT |-> first_q)
      else $error("first noise flag not set on entry");
   chk_noise_idle: assert property (@(posedge sys_clk) disable iff (srst)
      noise_aw && !first_q && !pass_done && !fault_pulse && !init
      |=> state_q == trm_pkg::ST_IDLE) else $error("second noise did not return idle");
   chk_fault_offline: assert property (@(posedge sys_clk) disable iff (srst)
      fault_pulse && !init |=> offline_q && state_q == trm_pkg::ST_OFFLINE)
      else $error("fault did not go offline");
   chk_total_lone: assert property (@(posedge sys_clk) disable iff (srst)
      total_ev && !init && !fault_pulse |=> lone_q ##0 state_q == trm_pkg::ST_IDLE)
      else $error("total failure not handled");
   chk_all_to_self: assert property (@(posedge sys_clk) disable iff (srst)
      tx_q.valid && tx_q.kind == trm_pkg::FR_INVITE2 |-> tx_q.to_self)
      else $error("invite-all not addressed to self");
   chk_omit_follow: assert property (@(posedge sys_clk) disable iff (srst)
      in_pass && !tx_q.valid && phase_q != trm_pkg::PH_TOTAL && !fault_pulse && !init
      |=> tx_q.valid && tx_q.omit_check == $past(omit_check_sequence_flag))
      else $error("omit flag not carried");

   // a handoff taken in idle always lands in the pass state next
   sequence s_handoff_taken;
      gap_check && !fault_pulse && !init;
   endsequence
   sequence s_pass_entered;
      state_q == trm_pkg::ST_PASS;
   endsequence
   chk_gap_solicit: assert property (@(posedge sys_clk) disable iff (srst)
      gap_count == 8'h00 ##0 s_handoff_taken
      |=> s_pass_entered ##0 phase_q == trm_pkg::PH_INVITE)
      else $error("zero gap did not solicit");
   chk_gap_direct: assert property (@(posedge sys_clk) disable iff (srst)
      gap_count != 8'h00 ##0 s_handoff_taken
      |=> s_pass_entered ##0 phase_q == trm_pkg::PH_PASS)
      else $error("nonzero gap did not pass directly");
   chk_lone_silent: assert property (@(posedge sys_clk) disable iff (srst)
      state_q == trm_pkg::ST_IDLE && handoff_req && lone_q && !data_pending && !fault_pulse
      |=> state_q == trm_pkg::ST_IDLE) else $error("lone station left idle");
   chk_lone_clear: assert property (@(posedge sys_clk) disable iff (srst)
      rx.valid_other && !total_ev |=> !lone_q) else $error("lone flag not cleared");
   chk_pass_order: assert property (@(posedge sys_clk) disable iff (srst)
      pass_fail && state_q inside {trm_pkg::ST_CHK_PASS, trm_pkg::ST_AWAIT}
      && !pass_done && !noise_aw && !fault_pulse && !init
      |=> phase_q == trm_pkg::trm_phase_e'($past(phase_q) + 3'h1))
      else $error("handoff phase out of order");
   chk_retry_step: assert property (@(posedge sys_clk) disable iff (srst)
      resp_timeout && retry_q != 4'h0 && !retry_load |=> retry_q == $past(retry_q) - 4'h1)
      else $error("retry count did not step");
endmodule : trm_ring_maint

/* File: rtl/trm_pkg.sv */
// Purpose: shared constants and types for the token bus ring maintenance block
// Assumes: one station clock sys_clk at 50 MHz, synchronous active-high reset srst
// Notes:   registers sit on one aligned word each behind an Avalon-MM slave
//
// What this block does
// - Solicit gap counter 0..255 checked before handoff; zero sends invitation, opens window.
// - Nonzero solicit gap at handoff: decrement by one and pass token directly.
// - Anything heard in invitation response windows clears the solicit gap counter.
// - Retry-left counter 0..ceiling limits retransmissions after response timeout.
// - Omit-check-sequence flag makes transmitter skip appending the check sequence.
// - Failure tally 0..7 increments on contention end or on a pass failure in the successor re-query phase.
// - Failure tally clears on winning demand-in contention or successful handoff.
// - Tally reaching 7 reports faulty transmitter, goes offline, leaves ring.
// - Entering await-response sets first-noise-pending; first noise burst clears it.
// - Noise burst with first-noise-pending false abandons wait and returns idle.
// - Handoff phases step in fixed order invitation through total failure.
// - Invitation phase sends invitation, checks response; pass phases send token, check pass.
// - Both successor query phases send a query frame and await response.
// - Invite-all sends two-window invitation to own address, then awaits response.
// - Total failure sets lone-station flag; pending data self-passes, else idle.
// - After total failure stay silent until data pending or valid foreign frame.
// - Valid frame from another station clears the lone-station flag.
package trm_pkg;
   // register byte offsets
   localparam logic [3:0] OFF_CTRL   = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_IRQ    = 4'h8;
   localparam logic [3:0] OFF_MASK   = 4'hc;
   // control field positions
   localparam int CTRL_GAP_LSB   = 0;  // 8-bit solicit gap reload
   localparam int CTRL_RETRY_LSB = 8;  // 4-bit retry ceiling
   localparam int CTRL_OMIT      = 12; // omit check sequence
   localparam int CTRL_INIT      = 13; // protocol init strobe
   // irq bit positions
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_TOTAL = 1;
   localparam int IRQ_RETRY = 2;
   // reset values and limits
   localparam logic [7:0] GAP_MAX       = 8'hff;
   localparam logic [3:0] RETRY_RESET   = 4'h3;
   localparam logic [2:0] FAULT_LIMIT   = 3'h7;
   localparam logic [1:0] INVITE_ALL_WN = 2'h2;

   typedef enum logic [2:0] {
      PH_INVITE   = 3'b000,
      PH_PASS     = 3'b001,
      PH_REPASS   = 3'b010,
      PH_QUERY    = 3'b011,
      PH_REQUERY  = 3'b100,
      PH_ALL      = 3'b101,
      PH_TOTAL    = 3'b110
   } trm_phase_e;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_PASS     = 3'b001,
      ST_CHK_RESP = 3'b010,
      ST_CHK_PASS = 3'b011,
      ST_AWAIT    = 3'b100,
      ST_OFFLINE  = 3'b101
   } trm_state_e;

   // frame send request toward the transmitter
   typedef enum logic [2:0] {
      FR_NONE    = 3'b000,
      FR_INVITE1 = 3'b001,
      FR_INVITE2 = 3'b010,
      FR_QUERY   = 3'b011,
      FR_TOKEN   = 3'b100
   } trm_frame_e;

   typedef struct packed {
      logic       valid;
      trm_frame_e kind;
      logic       to_self;     // destination is own station address
      logic       omit_check;  // do not append check sequence
   } trm_tx_s;

   // receive-side events
   typedef struct packed {
      logic heard_any;   // any activity during response windows
      logic noise;       // noise burst
      logic valid_other; // valid frame from another station
      logic successor;   // valid successor answer
   } trm_rx_s;
endpackage : trm_pkg

/* File: rtl/trm_fault_tally.sv */
// Purpose: transmitter failure tally with fault report
// Assumes: inc and clr are one-cycle pulses
// Notes:   clear wins over increment in the same cycle, success proves the transmitter
`timescale 1ns/100ps
module trm_fault_tally
(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       init,
   input  wire logic       inc,
   input  wire logic       clr,
   output logic [2:0]      tally,
   output logic            fault
);
   logic [2:0] tally_q;
   logic [2:0] tally_d;
   wire        hit_limit = inc && !clr && (tally_q == trm_pkg::FAULT_LIMIT - 3'h1);

   // saturating tally
   always_comb
   begin
      tally_d = tally_q;
      if (clr)
         tally_d = 3'h0;
      else if (inc && tally_q != trm_pkg::FAULT_LIMIT)
         tally_d = tally_q + 3'h1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst || init)
         tally_q <= 3'h0;
      else
         tally_q <= tally_d;
   end

   assign tally = tally_q;
   assign fault = hit_limit;

   chk_tally_clears: assert property (@(posedge sys_clk) disable iff (srst)
      clr && !init |=> tally_q == 3'h0) else $error("tally not cleared");
   chk_tally_steps: assert property (@(posedge sys_clk) disable iff (srst)
      inc && !clr && !init && tally_q < 3'h7 |=> tally_q == $past(tally_q) + 3'h1)
      else $error("tally did not step");
endmodule : trm_fault_tally

/* File: rtl/trm_gap_counter.sv */
// Purpose: solicit gap counter consulted at each token handoff
// Assumes: check is a one-cycle pulse at handoff time
// Notes:   heard clears after the decision, so an invitation is sent next handoff
`timescale 1ns/100ps
module trm_gap_counter
(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       init,
   input  wire logic       check,
   input  wire logic       heard,
   input  wire logic [7:0] reload,
   output logic            solicit,
   output logic [7:0]      count
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;

   assign solicit = (cnt_q == 8'h00);

   // heard wins over reload and decrement
   always_comb
   begin
      cnt_d = cnt_q;
      if (heard)
         cnt_d = 8'h00;
      else if (check && !solicit)
         cnt_d = cnt_q - 8'h01;
      else if (check && solicit)
         cnt_d = (reload > trm_pkg::GAP_MAX) ? trm_pkg::GAP_MAX : reload;
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst || init)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_d;
   end

   assign count = cnt_q;

   chk_gap_decrement: assert property (@(posedge sys_clk) disable iff (srst)
      check && cnt_q != 8'h00 && !heard && !init |=> cnt_q == $past(cnt_q) - 8'h01)
      else $error("gap counter did not decrement");
   chk_gap_heard_clear: assert property (@(posedge sys_clk) disable iff (srst)
      heard |=> cnt_q == 8'h00) else $error("gap counter not cleared");
endmodule : trm_gap_counter

/* File: bench/trm_peer_model.sv */
// Purpose: far-side transmitter and peer medium taking frame requests
// Assumes: tx holds valid until tx_ready is seen high
// Notes:   lag sets how long a frame waits, so both prompt and slow media are seen
`timescale 1ns/100ps
module trm_peer_model
(
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire trm_pkg::trm_tx_s tx,
   input  wire logic [1:0]       lag,
   output logic                  tx_ready
);
   logic [1:0] wait_q;
   // ready pulses for one cycle only, so a stale ready never takes the next frame
   always_ff @(posedge sys_clk)
   begin
      if (srst || !tx.valid || tx_ready)
      begin
         tx_ready <= 1'b0;
         wait_q   <= 2'h0;
      end
      else if (wait_q == lag)
         tx_ready <= 1'b1;
      else
         wait_q <= wait_q + 2'h1;
   end
endmodule : trm_peer_model

/* File: bench/trm_ring_maint_test.sv */
// Purpose: self-checking bench for the ring maintenance block
// Assumes: 50 MHz sys_clk, events are one-cycle pulses
// Notes:   expected frames queue up as {kind, to_self, omit}
`timescale 1ns/100ps
module trm_ring_maint_test;
   localparam int HO = 0, RL = 1, CE = 2, CW = 3, POK = 4, PF = 5, RT = 6, WD = 7;
   localparam int SUC = 8, VO = 9, NZ = 10, HRD = 11;
   localparam logic [4:0] INV1 = {trm_pkg::FR_INVITE1, 2'b00};
   localparam logic [4:0] TOK  = {trm_pkg::FR_TOKEN, 2'b00};
   localparam logic [4:0] QRY  = {trm_pkg::FR_QUERY, 2'b01};
   localparam logic [4:0] INV2 = {trm_pkg::FR_INVITE2, 2'b11};
   logic sys_clk, srst, avs_read, avs_write, avs_waitrequest, irq, tx_ready;
   logic retransmit, faulty_transmitter, offline, in_ring, lone_station, dp;
   logic [3:0]       avs_address, avs_byteenable;
   logic [31:0]      avs_writedata, avs_readdata, rd;
   logic [11:0]      ev;
   logic [1:0]       lag;
   logic [7:0]       gap;
   logic [4:0]       frame_q[$];
   trm_pkg::trm_tx_s tx;
   int errors, checks_done, frames_seen, faults_seen, retries_seen, seed;

   trm_ring_maint dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .handoff_req(ev[HO]),
      .data_pending(dp), .contention_end(ev[CE]), .contention_won(ev[CW]),
      .pass_ok(ev[POK]), .pass_fail(ev[PF]), .resp_timeout(ev[RT]), .window_done(ev[WD]),
      .retry_load(ev[RL]), .rx(trm_pkg::trm_rx_s'(ev[11:8])), .tx_ready(tx_ready), .tx(tx),
      .retransmit(retransmit), .faulty_transmitter(faulty_transmitter), .offline(offline),
      .in_ring(in_ring), .lone_station(lone_station));
   trm_peer_model peer (.sys_clk(sys_clk), .srst(srst), .tx(tx), .lag(lag),
      .tx_ready(tx_ready));

   // free-running station clock
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task check(input string what, input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask : check

   // one avalon access, held until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      if (n >= 20) check("bus answer", 0, 1);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task status(input string what, input logic [31:0] m, input logic [31:0] want);
      bus(1'b0, 4'h4, 32'h0);
      check(what, rd & m, want);
   endtask : status

   task pulse(input int i);
      @(posedge sys_clk);
      ev[i] <= 1'b1;
      @(posedge sys_clk);
      ev[i] <= 1'b0;
   endtask : pulse

   task irq_is(input logic want);
      @(posedge sys_clk);
      check("irq", irq, want);
   endtask : irq_is

   // note the frame first, then raise the event, then wait for the medium to take it
   task step(input int i, input logic [4:0] f);
      int n;
      n = frames_seen;
      frame_q.push_back(f);
      lag <= 2'($random(seed));
      pulse(i);
      repeat (40) if (frames_seen == n) @(posedge sys_clk);
      if (frames_seen == n) check("frame taken", 0, 1);
   endtask : step

   task final_report;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   // watcher: pulse counts and the oldest expected frame against each frame taken
   always @(posedge sys_clk)
   begin
      if (faulty_transmitter === 1'b1) faults_seen++;
      if (retransmit === 1'b1) retries_seen++;
      if (tx.valid === 1'b1 && tx_ready === 1'b1)
      begin
         frames_seen++;
         if (frame_q.size() == 0)
            check("unexpected frame", {27'h0, tx.kind, tx.to_self, tx.omit_check}, 0);
         else
            check("frame", {tx.kind, tx.to_self, tx.omit_check}, frame_q.pop_front());
      end
   end

   // whole run needs a few hundred cycles, so this only cuts a hang
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      final_report;
   end

   initial
   begin
      seed = 32'h0000_0047; // starts at 71
      {errors, checks_done, frames_seen, faults_seen, retries_seen} = 160'h0;
      {srst, avs_read, avs_write, ev, lag, dp, avs_address, avs_writedata} = '0;
      srst = 1'b1;
      avs_byteenable = 4'hf;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      status("reset status", 32'hff7d, 32'h1);
      gap = 8'h20 | 8'($random(seed));
      bus(1'b1, 4'h0, {20'h0, 4'h2, gap});
      step(HO, INV1);
      pulse(HRD);
      step(WD, TOK);
      pulse(POK);
      step(HO, INV1);
      step(WD, TOK);
      pulse(POK);
      step(HO, TOK);
      pulse(POK);
      $display("test gap done");
      step(HO, TOK);
      step(PF, TOK);
      step(PF, QRY & 5'h1e);
      pulse(NZ);
      pulse(HO);
      repeat (10) @(posedge sys_clk);
      pulse(NZ);
      step(HO, TOK);
      pulse(POK);
      step(HO, TOK);
      step(PF, TOK);
      step(PF, QRY & 5'h1e);
      pulse(SUC); // a successor answer ends the wait, next handoff proves idle
      $display("test noise done");
      bus(1'b1, 4'h0, {19'h0, 1'b1, 4'h2, gap});
      bus(1'b1, 4'hc, 32'h7);
      step(HO, TOK | 5'h1);
      step(PF, TOK | 5'h1);
      step(PF, QRY);
      step(PF, QRY);
      step(PF, INV2);
      pulse(PF);
      repeat (20) @(posedge sys_clk);
      irq_is(1'b1);
      status("lone and tally", 32'h7c, 32'h18);
      pulse(HO);
      repeat (8) @(posedge sys_clk); // any frame here is flagged unexpected
      dp <= 1'b1;
      step(HO, TOK | 5'h1);
      pulse(VO);
      status("lone cleared", 32'h8, 32'h0);
      $display("test total failure done");
      bus(1'b1, 4'h8, 32'h2);
      irq_is(1'b0);
      bus(1'b1, 4'hc, 32'h0);
      pulse(CW);
      status("tally won", 32'h70, 32'h0);
      repeat (6) pulse(CE);
      status("tally six", 32'h74, 32'h60);
      pulse(CE);
      repeat (2) @(posedge sys_clk);
      check("fault reports", faults_seen, 1);
      status("offline", 32'h5, 32'h4);
      irq_is(1'b0);
      bus(1'b1, 4'hc, 32'h1);
      irq_is(1'b1);
      bus(1'b1, 4'h8, 32'h7);
      irq_is(1'b0);
      pulse(HO);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped read", rd, 32'h0);
      $display("test fault done");
      bus(1'b1, 4'h0, 32'h2200);
      status("after init", 32'hff7c, 32'h0);
      pulse(RL);
      repeat (3) pulse(RT);
      repeat (2) @(posedge sys_clk);
      check("retransmits", retries_seen, 2);
      check("frames left", 32'(frame_q.size()), 32'h0);
      $display("test retry done");
      final_report;
   end
endmodule : trm_ring_maint_test
